// [design/adc_cfg_pkg.sv]
// Behaviour
// - writing bit 0 starts self-test
// - phase code counts whole input-clock delay cycles
// - code seven gives seven cycles delay
// - phase moves output clock, sampling unchanged
// - strength codes select one to four segments
package adc_cfg_pkg;

  // ==========================================================
  // register offsets
  localparam logic [7:0] self_test_control_off = 8'h0e;
  localparam logic [7:0] offset_trim_off = 8'h10;
  localparam logic [7:0] output_format_control_off = 8'h14;
  localparam logic [7:0] output_drive_strength_off = 8'h15;
  localparam logic [7:0] output_clock_phase_off = 8'h16;
  localparam logic [7:0] output_fine_delay_off = 8'h17;
  localparam logic [7:0] user_pattern_one_low_off = 8'h19;

  // ==========================================================
  // reset values
  localparam logic [7:0] self_test_control_rst = 8'h00;
  localparam logic [7:0] offset_trim_rst = 8'h00;
  localparam logic [7:0] output_format_control_rst = 8'h00;
  localparam logic [7:0] output_drive_strength_rst = 8'h22;
  localparam logic [7:0] output_clock_phase_rst = 8'h00;
  localparam logic [7:0] output_fine_delay_rst = 8'h00;
  localparam logic [7:0] user_pattern_one_low_rst = 8'h00;

  // ==========================================================
  // field positions
  localparam int self_test_run_bit = 0;
  localparam int self_test_initialize_bit = 2;
  localparam int phase_invert_bit = 7;
  localparam int phase_lsb = 0;
  localparam int phase_width = 3;
  localparam int drive_fields = 4;
  localparam int channels = 2;
  localparam int sample_width = 12;
  localparam logic [7:0] self_test_control_mask = 8'h05;
  localparam logic [7:0] output_clock_phase_mask = 8'h87;
  localparam logic [7:0] output_fine_delay_mask = 8'ha7;
  localparam logic [7:0] output_format_control_mask = 8'hf7;
  localparam logic [sample_width-1:0] sample_max = 12'hfff;

  // register port request
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_req_t;

endpackage

// [design/adc_output_config_registers.sv]
`timescale 1ns/1ns
module adc_output_config_registers import adc_cfg_pkg::*; (
  input wire logic clock,
  input wire logic rstn,
  input wire reg_req_t req,
  input wire logic [channels-1:0] chan_mask,
  input wire logic [2:0] div_ratio,
  input wire logic [sample_width-1:0] sample_a,
  input wire logic [sample_width-1:0] sample_b,
  output logic [7:0] rdata,
  output logic self_test_start,
  output logic self_test_initialize,
  output logic [7:0] format_ctrl,
  output logic [4*drive_fields-1:0] drive_segments,
  output logic sample_en,
  output logic output_data_clock,
  output logic [7:0] fine_delay,
  output logic [7:0] user_pattern_one_low,
  output logic [sample_width-1:0] trimmed_a,
  output logic [sample_width-1:0] trimmed_b
);

  // ==========================================================
  // helpers
  // two-bit strength code to thermometer segment enables
  function automatic logic [3:0] segments(input logic [1:0] code);
    case (code)
      2'h0: segments = 4'h1;
      2'h1: segments = 4'h3;
      2'h2: segments = 4'h7;
      default: segments = 4'hf;
    endcase
  endfunction

  // unsigned sample plus signed trim, clamped to range
  function automatic logic [sample_width-1:0] trim(input logic [sample_width-1:0] s, input logic [7:0] o);
    logic [13:0] sum;
    sum = {2'h0, s} + {{6{o[7]}}, o};
    if (sum[13]) begin
      trim = '0;
    end else if (sum[12]) begin
      trim = sample_max;
    end else begin
      trim = sum[sample_width-1:0];
    end
  endfunction

  // ==========================================================
  // registers
  logic [7:0] self_test_control_r;
  logic [7:0] offset_trim_r [channels];
  logic [7:0] output_format_control_r;
  logic [7:0] output_drive_strength_r;
  logic [7:0] output_clock_phase_r;
  logic [7:0] output_fine_delay_r;
  logic [7:0] user_pattern_one_low_r;
  logic [7:0] rdata_r;
  logic start_r;
  logic init_r;

  // address decode
  wire wr_test = req.wr && req.addr == self_test_control_off;
  wire wr_trim = req.wr && req.addr == offset_trim_off;
  wire wr_fmt = req.wr && req.addr == output_format_control_off;
  wire wr_drv = req.wr && req.addr == output_drive_strength_off;
  wire wr_phase = req.wr && req.addr == output_clock_phase_off;
  wire wr_delay = req.wr && req.addr == output_fine_delay_off;
  wire wr_patt = req.wr && req.addr == user_pattern_one_low_off;
  // trim read comes from channel a unless only b is indexed
  wire [7:0] trim_rd = (chan_mask == 2'h2) ? offset_trim_r[1] : offset_trim_r[0];
  // read mux, unmapped addresses return zero
  wire [7:0] rd_nxt =
    (req.addr == self_test_control_off) ? self_test_control_r :
    (req.addr == offset_trim_off) ? trim_rd :
    (req.addr == output_format_control_off) ? output_format_control_r :
    (req.addr == output_drive_strength_off) ? output_drive_strength_r :
    (req.addr == output_clock_phase_off) ? output_clock_phase_r :
    (req.addr == output_fine_delay_off) ? output_fine_delay_r :
    (req.addr == user_pattern_one_low_off) ? user_pattern_one_low_r : 8'h00;

  // control register writes
  always_ff @(posedge clock) begin
    if (!rstn) begin
      self_test_control_r <= self_test_control_rst;
      output_format_control_r <= output_format_control_rst;
      output_drive_strength_r <= output_drive_strength_rst;
      output_clock_phase_r <= output_clock_phase_rst;
      output_fine_delay_r <= output_fine_delay_rst;
      user_pattern_one_low_r <= user_pattern_one_low_rst;
    end else begin
      if (wr_test) self_test_control_r <= req.wdata & self_test_control_mask;
      if (wr_fmt) output_format_control_r <= req.wdata & output_format_control_mask;
      if (wr_drv) output_drive_strength_r <= req.wdata;
      if (wr_phase) output_clock_phase_r <= req.wdata & output_clock_phase_mask;
      if (wr_delay) output_fine_delay_r <= req.wdata & output_fine_delay_mask;
      if (wr_patt) user_pattern_one_low_r <= req.wdata;
    end
  end

  // per-channel trim, written only where the channel is indexed
  genvar ch;
  generate
    for (ch = 0; ch < channels; ch++) begin : g_trim
      always_ff @(posedge clock) begin
        if (!rstn) begin
          offset_trim_r[ch] <= offset_trim_rst;
        end else if (wr_trim && chan_mask[ch]) begin
          offset_trim_r[ch] <= req.wdata;
        end
      end
    end
  endgenerate

  // self-test start and init pulses, read data register
  always_ff @(posedge clock) begin
    if (!rstn) begin
      start_r <= 1'b0;
      init_r <= 1'b0;
      rdata_r <= 8'h00;
    end else begin
      start_r <= wr_test && req.wdata[self_test_run_bit];
      init_r <= wr_test && req.wdata[self_test_initialize_bit];
      if (req.rd) rdata_r <= rd_nxt;
    end
  end

  // ==========================================================
  // input clock divider and output clock phase
  logic [2:0] div_cnt_r;
  logic [6:0] tap_r;
  logic out_clk_r;
  wire [2:0] phase = output_clock_phase_r[phase_lsb +: phase_width];
  // sampling runs the cycle after divider wrap, at count zero, whatever the phase
  wire div_wrap = div_cnt_r >= div_ratio;
  wire sample_pulse = div_cnt_r == 3'h0;
  // pick the divider phase delayed by the code in input cycles
  wire out_clk_pick = (phase == 3'h0) ? sample_pulse : tap_r[phase - 3'h1];

  // divider count and delay line, seven taps cover the largest code
  always_ff @(posedge clock) begin
    if (!rstn) begin
      div_cnt_r <= 3'h0;
      tap_r <= 7'h00;
      out_clk_r <= 1'b0;
    end else begin
      div_cnt_r <= div_wrap ? 3'h0 : div_cnt_r + 3'h1;
      tap_r <= {tap_r[5:0], sample_pulse};
      out_clk_r <= out_clk_pick;
    end
  end

  // ==========================================================
  // trimmed samples
  logic [sample_width-1:0] trim_a_r;
  logic [sample_width-1:0] trim_b_r;

  // apply each channel's signed trim
  always_ff @(posedge clock) begin
    if (!rstn) begin
      trim_a_r <= '0;
      trim_b_r <= '0;
    end else begin
      trim_a_r <= trim(sample_a, offset_trim_r[0]);
      trim_b_r <= trim(sample_b, offset_trim_r[1]);
    end
  end

  // ==========================================================
  // outputs
  generate
    for (ch = 0; ch < drive_fields; ch++) begin : g_drive
      assign drive_segments[4*ch +: 4] = segments(output_drive_strength_r[2*ch +: 2]);
    end
  endgenerate
  assign rdata = rdata_r;
  assign self_test_start = start_r;
  assign self_test_initialize = init_r;
  assign format_ctrl = output_format_control_r;
  assign sample_en = sample_pulse;
  assign output_data_clock = out_clk_r ^ output_clock_phase_r[phase_invert_bit];
  assign fine_delay = output_fine_delay_r;
  assign user_pattern_one_low = user_pattern_one_low_r;
  assign trimmed_a = trim_a_r;
  assign trimmed_b = trim_b_r;

  // ==========================================================
  // checks
  // history that reaches back into reset is masked with $past(rstn) in the phase and trim checks
  a_test_start_pulse: assert property (@(posedge clock) disable iff (!rstn)
    (wr_test && req.wdata[self_test_run_bit]) |=> self_test_start ##1 !self_test_start)
    else $error("self-test start not pulsed after write");
  a_start_needs_write: assert property (@(posedge clock) disable iff (!rstn)
    !(wr_test && req.wdata[self_test_run_bit]) |=> !self_test_start)
    else $error("self-test start without a write");
  a_phase_zero_delay: assert property (@(posedge clock) disable iff (!rstn)
    (phase == 3'h0 && $past(phase) == 3'h0 && $past(rstn)) |-> out_clk_r == $past(sample_pulse))
    else $error("phase zero output clock delayed");
  a_phase_seven_delay: assert property (@(posedge clock) disable iff (!rstn)
    (phase == 3'h7 && $past(phase, 8) == 3'h7 && $past(rstn, 9)) |-> out_clk_r == $past(sample_pulse, 8))
    else $error("phase seven output clock not seven cycles late");
  a_sample_unchanged: assert property (@(posedge clock) disable iff (!rstn)
    $past(div_wrap) |-> sample_en)
    else $error("sampling moved by divider");
  a_drive_one_seg: assert property (@(posedge clock) disable iff (!rstn)
    output_drive_strength_r[1:0] == 2'h0 |-> drive_segments[3:0] == 4'h1)
    else $error("code zero not one segment");
  a_drive_four_seg: assert property (@(posedge clock) disable iff (!rstn)
    output_drive_strength_r[7:6] == 2'h3 |-> drive_segments[15:12] == 4'hf)
    else $error("code three not four segments");
  a_drive_rank: assert property (@(posedge clock) disable iff (!rstn)
    $countones(drive_segments[7:4]) == 32'(output_drive_strength_r[3:2]) + 1)
    else $error("segment count wrong");
  a_trim_signed: assert property (@(posedge clock) disable iff (!rstn)
    (offset_trim_r[0] == 8'hff && sample_a == 12'h800 && $past(rstn)) |=> trimmed_a == 12'h7ff)
    else $error("trim not signed");
  a_trim_high_clamp: assert property (@(posedge clock) disable iff (!rstn)
    (offset_trim_r[1] == 8'h7f && sample_b == sample_max && $past(rstn)) |=> trimmed_b == sample_max)
    else $error("positive trim not clamped at full scale");
  a_trim_index: assert property (@(posedge clock) disable iff (!rstn)
    (wr_trim && chan_mask == 2'h1) |=> $stable(offset_trim_r[1]))
    else $error("unindexed channel trim changed");

endmodule // adc_output_config_registers

// [testbench/reg_host_model.sv]
`timescale 1ns/1ns
// ==========
// host side: one-cycle register strobes launched at the falling edge
module reg_host_model import adc_cfg_pkg::*; (
  input wire logic clock,
  input wire logic [7:0] rdata,
  output reg_req_t req
);
  initial req = '0;
  // write one byte; released lines show inverted values
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clock);
    req <= '{1'b1, 1'b0, a, d};
    @(negedge clock);
    req <= '{1'b0, 1'b0, ~a, ~d};
  endtask
  // read one byte; data is settled one cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [7:0] q);
    @(negedge clock);
    req <= '{1'b0, 1'b1, a, 8'h5a};
    @(negedge clock);
    q = rdata;
    req <= '{1'b0, 1'b0, ~a, 8'ha5};
  endtask
endmodule // reg_host_model

// [testbench/tb_adc_output_config_registers.sv]
`timescale 1ns/1ns
// ==========
// self-checking bench for the output configuration registers
module tb_adc_output_config_registers import adc_cfg_pkg::*; ;
  logic clock = 1'b0;
  logic rstn = 1'b0;
  reg_req_t req;
  logic [channels-1:0] chan_mask = 2'b01;
  logic [2:0] div_ratio = 3'h0;
  logic [sample_width-1:0] sample_a = '0, sample_b = '0, ta, tb;
  logic [7:0] rdata, fmt, fine, upat;
  logic start, init, sen, odc;
  logic [15:0] seg;
  int n_errors = 0;
  int samples_checked = 0;
  always #10 clock = ~clock;
  reg_host_model reg_host_model_inst (.clock(clock), .rdata(rdata), .req(req));
  adc_output_config_registers adc_output_config_registers_inst (.clock(clock), .rstn(rstn), .req(req),
    .chan_mask(chan_mask), .div_ratio(div_ratio), .sample_a(sample_a), .sample_b(sample_b),
    .rdata(rdata), .self_test_start(start), .self_test_initialize(init), .format_ctrl(fmt),
    .drive_segments(seg), .sample_en(sen), .output_data_clock(odc), .fine_delay(fine),
    .user_pattern_one_low(upat), .trimmed_a(ta), .trimmed_b(tb));
  // ==========
  // compare, closing report and expectations
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    samples_checked++;
    if (g !== e) begin
      n_errors++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic finish_test();
    $display("checked %0d mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // thermometer groups of the drive strength byte
  function automatic logic [15:0] segs(input logic [7:0] v);
    for (int k = 0; k < 4; k++) segs[4*k +: 4] = 4'hf >> (3 - v[2*k +: 2]);
  endfunction
  // signed trim added to the sample and clamped to its range
  function automatic logic [11:0] trim(input logic [11:0] s, input logic [7:0] t);
    int r;
    r = int'(s) + int'($signed(t));
    trim = r < 0 ? 12'h000 : (r > 4095 ? 12'hfff : r[11:0]);
  endfunction
  // bounded wait for the divider pulse
  task automatic wait_sen();
    int i;
    for (i = 0; i < 20 && sen !== 1'b1; i++) @(negedge clock);
    if (i == 20) begin
      n_errors++;
      finish_test();
    end
  endtask
  // ==========
  // main sequence
  initial begin
    logic [7:0] q, d, t0, t1;
    logic [7:0] ad [7] = '{self_test_control_off, offset_trim_off, output_format_control_off,
      output_drive_strength_off, output_clock_phase_off, output_fine_delay_off, user_pattern_one_low_off};
    logic [7:0] mk [7] = '{8'h05, 8'hff, 8'hf7, 8'hff, 8'h87, 8'ha7, 8'hff};
    logic [7:0] rv [7] = '{8'h00, 8'h00, 8'h00, 8'h22, 8'h00, 8'h00, 8'h00};
    int n, m;
    void'($urandom(32'h44da));
    repeat (16) @(negedge clock);
    rstn = 1'b1;
    // reset values, unmapped read, then random write and read back
    chk(seg, segs(8'h22));
    for (int k = 0; k < 7; k++) begin
      reg_host_model_inst.rd(ad[k], q);
      chk(16'(q), 16'(rv[k]));
    end
    reg_host_model_inst.rd(8'h11, q);
    chk(16'(q), 16'h0000);
    repeat (4) for (int k = 0; k < 7; k++) begin
      d = 8'($urandom);
      reg_host_model_inst.wr(ad[k], d);
      if (k == 3) chk(seg, segs(d));
      if (k == 2) chk(16'(fmt), 16'(d & mk[2]));
      if (k == 5) chk(16'(fine), 16'(d & mk[5]));
      if (k == 6) chk(16'(upat), 16'(d));
      reg_host_model_inst.rd(ad[k], q);
      chk(16'(q), 16'(d & mk[k]));
    end
    $display("test registers done");
    // self-test start and initialize pulses
    foreach (mk[k]) begin
      d = (k < 2) ? 8'h01 << (2 * k) : 8'($urandom);
      reg_host_model_inst.wr(self_test_control_off, d);
      chk(16'({start, init}), 16'({d[0], d[2]}));
      @(negedge clock);
      chk(16'({start, init}), 16'h0000);
    end
    $display("test self_test done");
    // output clock phase against divider pulse, random polarity per phase code
    for (int p = 0; p < 8; p++) begin
      div_ratio = 3'($urandom);
      d = {1'($urandom), 4'h0, 3'(p)};
      reg_host_model_inst.wr(output_clock_phase_off, d);
      repeat (12) @(negedge clock);
      wait_sen();
      for (n = 0; n < 20 && odc === d[7]; n++) @(negedge clock);
      chk(16'(n), 16'((p + 1) % (div_ratio + 1)));
      wait_sen();
      @(negedge clock);
      for (m = 1; m < 20 && sen !== 1'b1; m++) @(negedge clock);
      chk(16'(m), 16'(div_ratio + 1));
    end
    $display("test phase done");
    // per-channel signed trim with clamping corners
    for (int k = 0; k < 12; k++) begin
      t0 = k < 2 ? 8'h80 : (k == 2 ? 8'hff : 8'($urandom));
      t1 = k < 2 ? 8'h7f : 8'($urandom);
      chan_mask = 2'b01;
      reg_host_model_inst.wr(offset_trim_off, t0);
      chan_mask = 2'b10;
      reg_host_model_inst.wr(offset_trim_off, t1);
      reg_host_model_inst.rd(offset_trim_off, q);
      chk(16'(q), 16'(t1));
      sample_a = k < 2 ? {12{k[0]}} : (k == 2 ? 12'h800 : 12'($urandom));
      sample_b = k < 2 ? {12{k[0]}} : 12'($urandom);
      @(negedge clock);
      chk(16'(ta), 16'(trim(sample_a, t0)));
      chk(16'(tb), 16'(trim(sample_b, t1)));
    end
    // both channels indexed take one write; each reads it back
    chan_mask = 2'b11;
    reg_host_model_inst.wr(offset_trim_off, 8'h3c);
    chan_mask = 2'b10;
    reg_host_model_inst.rd(offset_trim_off, q);
    chk(16'(q), 16'h003c);
    chan_mask = 2'b01;
    reg_host_model_inst.rd(offset_trim_off, q);
    chk(16'(q), 16'h003c);
    $display("test trim done");
    finish_test();
  end
endmodule // tb_adc_output_config_registers
